// File: ccr_defines.svh
// offsets, field positions, reset values and timing counts of the card configuration registers
`ifndef CCR_DEFINES_SVH
`define CCR_DEFINES_SVH

// ****************************************
// register offsets in attribute space
// ****************************************
`define CCR_OFS_OPTION   10'h200
`define CCR_OFS_CFGSTAT  10'h202
`define CCR_OFS_PINREPL  10'h204
`define CCR_OFS_SOCKET   10'h206

// ****************************************
// field positions
// ****************************************
`define CCR_OPT_SRST     7
`define CCR_OPT_LEVEL    6
`define CCR_CS_CHG       7
`define CCR_CS_SIGEN     6
`define CCR_CS_NARROW    5
`define CCR_CS_PWD       2
`define CCR_CS_IRQ       1
`define CCR_PR_RCHG      5
`define CCR_PR_RLIVE     1
`define CCR_SC_COPY      4

// ****************************************
// reset values and fixed bits
// ****************************************
`define CCR_RST_OPTION   8'h00
`define CCR_RST_CFGSTAT  8'h00
`define CCR_RST_PINREPL  8'h0c
`define CCR_RST_SOCKET   8'h00
`define CCR_PR_FIXED     8'h0c
// sampled pins at rest: resets and ide low, all four strobes high, lines low
`define CCR_PIN_IDLE     24'h3c0000

// ****************************************
// mode index codes
// ****************************************
`define CCR_IDX_MEM      6'h00
`define CCR_IDX_IO_CONT  6'h01
`define CCR_IDX_IO_PRI   6'h02
`define CCR_IDX_IO_SEC   6'h03

// ****************************************
// timing: init, power transition, idle time in ns at 8 ns per cycle
// ****************************************
`define CCR_CLK_NS       8
`define CCR_INIT_NS      800
`define CCR_INIT_CYC     (`CCR_INIT_NS / `CCR_CLK_NS)
`define CCR_PWR_NS       400
`define CCR_PWR_CYC      (`CCR_PWR_NS / `CCR_CLK_NS)
`define CCR_IDLE_NS      8000
`define CCR_IDLE_CYC     (`CCR_IDLE_NS / `CCR_CLK_NS)
`define CCR_CNT_W        12

`endif

// File: ccr_pkg.sv
// types shared by the card configuration register block
package ccr_pkg;

  // ****************************************
  // card operating modes and decoded map
  // ****************************************
  typedef enum logic [2:0] {
    CCR_MAP_MEM,
    CCR_MAP_IO_CONT,
    CCR_MAP_IO_PRI,
    CCR_MAP_IO_SEC,
    CCR_MAP_NONE
  } ccr_map_t;

  // attribute bus request, sampled from pins
  typedef struct packed {
    logic       reg_sel;
    logic       ce1;
    logic       oe;
    logic       we;
    logic [9:0] addr;
    logic [7:0] wdata;
  } ccr_bus_t;

  // task file decode request from the core
  typedef struct packed {
    logic        io_cycle;
    logic [10:0] addr;
  } ccr_tf_req_t;

endpackage : ccr_pkg

// File: ccr_config_regs.sv
// card configuration register bank with pin sampling and power state control
// Summary of operation
// - writing soft reset bit resets card like hard reset; bit itself stays set
// - hard reset clears configuration state and starts internal initialization
// - option bit6 selects pulse (0) or level (1) interrupt requests
// - mode index returns to zero on power-on, hard and soft reset
// - mode index picks memory, contiguous, primary or secondary I/O decode
// - change flag mirrors ready-changed; drives status-change pin low in I/O mode
// - status-change enable zero keeps status-change pin high
// - power-down bit one enters sleep, zero returns to active
// - ready shows busy after power-down bit changes until state reached
// - card sleeps itself when idle and wakes on command
// - interrupt-pending bit shows internal request in any mode until serviced
// - interrupt-pending reads zero when interrupt-disable bit is set
// - ready-changed set when live ready changes; host may write it
// - live ready reads ready pin; written value masks ready-changed
// - pin replacement register resets to 0ch
// - option, status and socket registers reset to 00h; unused bits zero
// - copy number bit4 is written by host and stays readable
// - configuration registers inaccessible in true IDE mode
`include "ccr_defines.svh"

module ccr_config_regs
  import ccr_pkg::*;
(
  // clock and power-on reset
  input  wire logic        clk,
  input  wire logic        rst,
  // card pins, asynchronous to clk
  input  wire logic        hard_reset_pin,
  input  wire logic        ide_mode_pin,
  input  wire ccr_bus_t    bus_pin,
  // data bus low byte, two signals
  output logic [7:0]       data_out,
  output logic             data_oe,
  // core side, same clock
  input  wire logic        core_irq,
  input  wire logic        irq_disable,
  input  wire logic        core_cmd,
  input  wire logic        core_busy,
  input  wire ccr_tf_req_t tf_req,
  // status pins and core controls
  output logic             status_change_pin_n,
  output logic             interrupt_request_pin_n,
  output logic             ready_pin,
  output logic             core_init,
  output logic             core_sleep,
  output logic             tf_hit,
  output ccr_map_t         card_map,
  output logic             narrow_host_flag
);

  // ****************************************
  // pin sampling: three flops, change counted when stages two and three agree
  // ****************************************
  localparam int SW = $bits(ccr_bus_t) + 2; // hard reset and ide mode pins plus the bus
  logic [SW-1:0] s1_reg, s2_reg, s3_reg, pin_reg;
  logic [SW-1:0] s1_next, s2_next, s3_next, pin_next;
  ccr_bus_t      bus_s;
  logic          hrst_s, ide_s;

  // sampling chain; stage one feeds only stage two
  always_comb begin
    s1_next  = {hard_reset_pin, ide_mode_pin, bus_pin};
    s2_next  = s1_reg;
    s3_next  = s2_reg;
    pin_next = (s2_reg == s3_reg) ? s3_reg : pin_reg;
  end

  // chain rests at idle pin levels so no false strobe or drive follows reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_reg  <= `CCR_PIN_IDLE;
      s2_reg  <= `CCR_PIN_IDLE;
      s3_reg  <= `CCR_PIN_IDLE;
      pin_reg <= `CCR_PIN_IDLE;
    end else begin
      s1_reg  <= s1_next;
      s2_reg  <= s2_next;
      s3_reg  <= s3_next;
      pin_reg <= pin_next;
    end
  end

  assign {hrst_s, ide_s, bus_s} = pin_reg;

  // ****************************************
  // access decode
  // ****************************************
  function automatic logic reg_hit(input ccr_bus_t b, input logic [9:0] ofs);
    // attribute select low, byte enable low, even address only
    reg_hit = !b.reg_sel && !b.ce1 && (b.addr == ofs);
  endfunction : reg_hit

  logic we_d_reg, we_d_next;
  logic wr_strobe;
  assign wr_strobe = !ide_s && !bus_s.we && we_d_reg;
  assign we_d_next = bus_s.we;

  // ****************************************
  // register state
  // ****************************************
  logic       srst_reg, srst_next;
  logic       level_reg, level_next;
  logic [5:0] index_reg, index_next;
  logic       sigen_reg, sigen_next;
  logic       narrow_reg, narrow_next;
  logic       pwd_reg, pwd_next;
  logic       rchg_reg, rchg_next;
  logic       rmask_reg, rmask_next;
  logic       copy_reg, copy_next;
  logic       rdy_d_reg, rdy_d_next;
  logic       card_reset;
  logic       ready_live;
  logic       change_flag;
  logic       irq_pending;

  // soft bit held as reset source
  // hard reset pin clears config state
  assign card_reset = hrst_s | srst_reg;

  // register write logic
  always_comb begin
    srst_next   = srst_reg;
    level_next  = level_reg;
    index_next  = index_reg;
    sigen_next  = sigen_reg;
    narrow_next = narrow_reg;
    pwd_next    = pwd_reg;
    rchg_next   = rchg_reg;
    rmask_next  = rmask_reg;
    copy_next   = copy_reg;
    rdy_d_next  = ready_live;
    if (wr_strobe && reg_hit(bus_s, `CCR_OFS_OPTION)) begin
      srst_next  = bus_s.wdata[`CCR_OPT_SRST];
      level_next = bus_s.wdata[`CCR_OPT_LEVEL];
      index_next = bus_s.wdata[5:0];
    end
    if (wr_strobe && reg_hit(bus_s, `CCR_OFS_CFGSTAT)) begin
      sigen_next  = bus_s.wdata[`CCR_CS_SIGEN];
      narrow_next = bus_s.wdata[`CCR_CS_NARROW];
      pwd_next    = bus_s.wdata[`CCR_CS_PWD];
    end
    if (wr_strobe && reg_hit(bus_s, `CCR_OFS_PINREPL)) begin
      rchg_next  = bus_s.wdata[`CCR_PR_RCHG];
      rmask_next = bus_s.wdata[`CCR_PR_RLIVE];
    end
    if ((ready_live != rdy_d_reg) && !rmask_next)
      rchg_next = 1'b1;
    if (wr_strobe && reg_hit(bus_s, `CCR_OFS_SOCKET)) begin
      copy_next = bus_s.wdata[`CCR_SC_COPY];
    end
    // index and config cleared on any reset
    // soft reset bit survives its own reset
    if (card_reset) begin
      level_next  = 1'b0;
      index_next  = `CCR_IDX_MEM;
      sigen_next  = 1'b0;
      narrow_next = 1'b0;
      pwd_next    = 1'b0;
      rchg_next   = 1'b0;
      rmask_next  = 1'b0;
      copy_next   = 1'b0;
    end
    if (hrst_s)
      srst_next = 1'b0;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      srst_reg   <= 1'(`CCR_RST_OPTION >> `CCR_OPT_SRST);
      level_reg  <= 1'b0;
      index_reg  <= `CCR_IDX_MEM;
      sigen_reg  <= 1'b0;
      narrow_reg <= 1'b0;
      pwd_reg    <= 1'b0;
      rchg_reg   <= 1'b0;
      rmask_reg  <= 1'b0;
      copy_reg   <= 1'b0;
      rdy_d_reg  <= 1'b0;
      we_d_reg   <= 1'b1;
    end else begin
      srst_reg   <= srst_next;
      level_reg  <= level_next;
      index_reg  <= index_next;
      sigen_reg  <= sigen_next;
      narrow_reg <= narrow_next;
      pwd_reg    <= pwd_next;
      rchg_reg   <= rchg_next;
      rmask_reg  <= rmask_next;
      copy_reg   <= copy_next;
      rdy_d_reg  <= rdy_d_next;
      we_d_reg   <= we_d_next;
    end
  end

  // ****************************************
  // power state machine: init, active, transitions, sleep
  // ****************************************
  typedef enum logic [2:0] {
    PS_INIT,
    PS_ACTIVE,
    PS_TO_SLEEP,
    PS_SLEEP,
    PS_TO_ACTIVE
  } ccr_pwr_t;

  ccr_pwr_t              ps_reg, ps_next;
  logic [`CCR_CNT_W-1:0] cnt_reg, cnt_next;
  logic [`CCR_CNT_W-1:0] idle_reg, idle_next;
  logic                  pwd_d_reg;

  // power transitions; a fresh power-down change restarts the wait
  always_comb begin
    ps_next   = ps_reg;
    cnt_next  = (cnt_reg != '0) ? cnt_reg - 1'b1 : cnt_reg;
    idle_next = (core_cmd || core_busy) ? '0 :
                (idle_reg == `CCR_CNT_W'(`CCR_IDLE_CYC)) ? idle_reg : idle_reg + 1'b1;
    unique case (ps_reg)
      PS_INIT:
        if (cnt_reg == '0)
          ps_next = PS_ACTIVE;
      PS_ACTIVE:
        // auto sleep when idle; the power-down bit acts through its change
        if (idle_reg == `CCR_CNT_W'(`CCR_IDLE_CYC)) begin
          ps_next  = PS_TO_SLEEP;
          cnt_next = `CCR_CNT_W'(`CCR_PWR_CYC);
        end
      PS_TO_SLEEP:
        if (cnt_reg == '0)
          ps_next = PS_SLEEP;
      PS_SLEEP:
        // besides clearing the power-down bit or a card reset, only a command wakes the card, so an idle sleep does not bounce
        if (core_cmd) begin
          ps_next  = PS_TO_ACTIVE;
          cnt_next = `CCR_CNT_W'(`CCR_PWR_CYC);
        end
      PS_TO_ACTIVE:
        if (cnt_reg == '0)
          ps_next = PS_ACTIVE;
    endcase
    // bit change forces busy until reached
    if (pwd_reg != pwd_d_reg) begin
      ps_next  = pwd_reg ? PS_TO_SLEEP : PS_TO_ACTIVE;
      cnt_next = `CCR_CNT_W'(`CCR_PWR_CYC);
    end
    if (card_reset) begin
      ps_next  = PS_INIT;
      cnt_next = `CCR_CNT_W'(`CCR_INIT_CYC);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ps_reg    <= PS_INIT;
      cnt_reg   <= `CCR_CNT_W'(`CCR_INIT_CYC);
      idle_reg  <= '0;
      pwd_d_reg <= 1'b0;
    end else begin
      ps_reg    <= ps_next;
      cnt_reg   <= cnt_next;
      idle_reg  <= idle_next;
      pwd_d_reg <= pwd_reg;
    end
  end

  // ready only in a settled state
  assign ready_live = (ps_reg == PS_ACTIVE || ps_reg == PS_SLEEP) && !core_busy;

  // ****************************************
  // status, decode and pin outputs
  // ****************************************
  ccr_map_t map_now;
  logic     io_mode;
  logic     tf_now;
  logic     irq_pulse_reg;

  always_comb begin
    unique case (index_reg)
      `CCR_IDX_MEM:     map_now = CCR_MAP_MEM;
      `CCR_IDX_IO_CONT: map_now = CCR_MAP_IO_CONT;
      `CCR_IDX_IO_PRI:  map_now = CCR_MAP_IO_PRI;
      `CCR_IDX_IO_SEC:  map_now = CCR_MAP_IO_SEC;
      default:          map_now = CCR_MAP_NONE;
    endcase
  end

  always_comb begin
    unique case (map_now)
      CCR_MAP_MEM:     tf_now = !tf_req.io_cycle && (tf_req.addr[10:4] == 7'h00 ||
                                tf_req.addr[10]);
      CCR_MAP_IO_CONT: tf_now = tf_req.io_cycle;
      CCR_MAP_IO_PRI:  tf_now = tf_req.io_cycle && (tf_req.addr[9:3] == 7'h3e ||
                                tf_req.addr[9:1] == 9'h1fb);
      CCR_MAP_IO_SEC:  tf_now = tf_req.io_cycle && (tf_req.addr[9:3] == 7'h2e ||
                                tf_req.addr[9:1] == 9'h1bb);
      default:         tf_now = 1'b0;
    endcase
  end

  assign io_mode     = (map_now != CCR_MAP_MEM) && (map_now != CCR_MAP_NONE);
  assign change_flag = rchg_reg;
  assign irq_pending = core_irq && !irq_disable;

  logic [7:0] rd_now;

  // read mux; fixed and unused bits read as documented
  always_comb begin
    rd_now = 8'h00;
    if (reg_hit(bus_s, `CCR_OFS_OPTION))
      rd_now = {srst_reg, level_reg, index_reg};
    if (reg_hit(bus_s, `CCR_OFS_CFGSTAT)) begin
      rd_now[`CCR_CS_CHG]    = change_flag;
      rd_now[`CCR_CS_SIGEN]  = sigen_reg;
      rd_now[`CCR_CS_NARROW] = narrow_reg;
      rd_now[`CCR_CS_PWD]    = pwd_reg;
      rd_now[`CCR_CS_IRQ]    = irq_pending;
    end
    if (reg_hit(bus_s, `CCR_OFS_PINREPL)) begin
      // fixed ones in bits 3 and 2
      rd_now                = `CCR_PR_FIXED;
      rd_now[`CCR_PR_RCHG]  = rchg_reg;
      rd_now[`CCR_PR_RLIVE] = ready_live;
    end
    if (reg_hit(bus_s, `CCR_OFS_SOCKET))
      rd_now[`CCR_SC_COPY] = copy_reg;
  end

  // registered outputs; data bus driven only on a low-byte read
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      data_out                <= 8'h00;
      data_oe                 <= 1'b0;
      status_change_pin_n     <= 1'b1;
      interrupt_request_pin_n <= 1'b1;
      irq_pulse_reg           <= 1'b0;
      ready_pin               <= 1'b0;
      core_init               <= 1'b1;
      core_sleep              <= 1'b0;
      tf_hit                  <= 1'b0;
      card_map                <= CCR_MAP_MEM;
      narrow_host_flag        <= 1'b0;
    end else begin
      data_out                <= rd_now;
      data_oe                 <= !ide_s && !bus_s.reg_sel && !bus_s.ce1 &&
                                 !bus_s.oe && !bus_s.addr[0];
      // pin low on flag in io mode with status change enabled
      status_change_pin_n     <= !(change_flag && sigen_reg && io_mode);
      irq_pulse_reg           <= irq_pending;
      // level follows request, pulse marks the rise
      interrupt_request_pin_n <= level_reg ? !irq_pending : !(irq_pending && !irq_pulse_reg);
      ready_pin               <= ready_live;
      core_init               <= ps_reg == PS_INIT;
      core_sleep              <= ps_reg == PS_SLEEP || ps_reg == PS_TO_SLEEP;
      tf_hit                  <= tf_now;
      card_map                <= map_now;
      narrow_host_flag        <= narrow_reg;
    end
  end

endmodule : ccr_config_regs

// File: ccr_chk_sva.sv
// port-level assertion checker for the card configuration registers
module ccr_chk
  import ccr_pkg::*;
(
  // clock and reset
  input wire logic     clk,
  input wire logic     rst,
  // watched pins
  input wire logic     hard_reset_pin,
  input wire logic     ide_mode_pin,
  input wire ccr_bus_t bus_pin,
  input wire logic     data_oe,
  input wire logic     core_irq,
  input wire logic     status_change_pin_n,
  input wire logic     interrupt_request_pin_n,
  input wire logic     ready_pin,
  input wire logic     core_init,
  input wire logic     tf_hit,
  input wire ccr_map_t card_map
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ****************
  // properties
  // ****************
  ide_quiet_a: assert property (ide_mode_pin [*8] |-> !data_oe)
    else $error("data bus driven in ide mode");
  oe_idle_a: assert property (bus_pin.oe [*8] |-> !data_oe)
    else $error("data bus driven without read strobe");
  odd_quiet_a: assert property (bus_pin.addr[0] [*8] |-> !data_oe)
    else $error("data bus driven for odd address");
  sts_mem_a: assert property ((card_map == CCR_MAP_MEM) [*2] |-> status_change_pin_n)
    else $error("status change low in memory mode");
  hrst_init_a: assert property (hard_reset_pin [*6] |=> core_init)
    else $error("hard reset did not start init");
  init_map_a: assert property (core_init [*3] |-> card_map == CCR_MAP_MEM)
    else $error("mode not memory during init");
  init_busy_a: assert property (core_init [*2] |-> !ready_pin)
    else $error("ready shown during init");
  irq_quiet_a: assert property (!core_irq [*4] |-> interrupt_request_pin_n)
    else $error("interrupt pin low without request");
  tf_none_a: assert property ((card_map == CCR_MAP_NONE) [*2] |-> !tf_hit)
    else $error("task file hit in unmapped mode");
  // main scenarios
  cover property ($rose(data_oe));
  cover property ($fell(status_change_pin_n));
  cover property ($fell(interrupt_request_pin_n));
  cover property (tf_hit);
endmodule : ccr_chk

bind ccr_config_regs ccr_chk u_chk (.clk, .rst, .hard_reset_pin, .ide_mode_pin, .bus_pin,
  .data_oe, .core_irq, .status_change_pin_n, .interrupt_request_pin_n, .ready_pin,
  .core_init, .tf_hit, .card_map);

// File: ccr_host.sv
// host socket controller model issuing attribute byte cycles
module ccr_host
  import ccr_pkg::*;
(
  // clock
  input  wire logic clk,
  // attribute bus pins
  output ccr_bus_t  bus
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************
  // bus cycle
  // ****************
  // idle: all strobes high
  initial bus = {4'hf, 10'h000, 8'h00};
  // byte cycle on the low lane, strobe held well past pin sampling
  task automatic cyc(input logic w, input logic [9:0] a, input logic [7:0] d);
    @(negedge clk);
    bus.reg_sel <= 1'b0;
    bus.ce1     <= 1'b0;
    bus.addr    <= a;
    bus.wdata   <= w ? d : ~bus.wdata;
    bus.we      <= !w;
    bus.oe      <= w;
    repeat (8) @(negedge clk);
    bus.we      <= 1'b1;
    bus.oe      <= 1'b1;
    bus.ce1     <= 1'b1;
    bus.reg_sel <= 1'b1;
    // released data lines do not keep the old value
    bus.wdata   <= ~bus.wdata;
    // strobes stay high long enough for the card to see the gap
    repeat (6) @(negedge clk);
  endtask : cyc
endmodule : ccr_host

// File: ccr_tb.sv
// self-checking bench for the card configuration registers
module tb import ccr_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst, hrst, ide, core_irq, irq_dis, core_cmd, oe_q;
  logic        data_oe, sts_n, irq_n, ready, init, sleep, hit, narrow;
  ccr_bus_t    bus;
  ccr_tf_req_t tf_req;
  ccr_map_t    map;
  logic [7:0]  data_out;
  int          bad_count, check_count;
  logic [7:0]  exp_q[$];
  localparam logic [11:0] hit_tab [4]  = '{12'h405, 12'h8a5, 12'h9f0, 12'hb77};
  localparam logic [11:0] miss_tab [5] = '{12'h010, 12'h000, 12'h9f8, 12'h978, 12'h9f0};

  ccr_config_regs DUT (.clk(clk), .rst(rst), .hard_reset_pin(hrst), .ide_mode_pin(ide),
    .bus_pin(bus), .data_out(data_out), .data_oe(data_oe), .core_irq(core_irq),
    .irq_disable(irq_dis), .core_cmd(core_cmd), .core_busy(1'b0), .tf_req(tf_req),
    .status_change_pin_n(sts_n), .interrupt_request_pin_n(irq_n), .ready_pin(ready),
    .core_init(init), .core_sleep(sleep), .tf_hit(hit), .card_map(map),
    .narrow_host_flag(narrow));
  ccr_host host (.clk(clk), .bus(bus));

  // ****************
  // tasks
  // ****************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host.cyc(1'b0, a, 8'h00); // byte read
  endtask : rd
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    host.cyc(1'b1, a, d); // byte write
  endtask : wr
  // command pulse keeps the card out of auto sleep
  task automatic cmd();
    core_cmd = 1'b1;
    @(negedge clk);
    core_cmd = 1'b0;
  endtask : cmd
  // held two cycles so either decode latency sees a stable request
  task automatic tf(input logic [11:0] r, input logic e);
    tf_req = r;
    repeat (2) @(negedge clk);
    chk(8'(hit), 8'(e)); // window decode
    tf_req = '0;
    // let the idle request stand one cycle before the next one
    @(negedge clk);
  endtask : tf
  task automatic wait_ready();
    int n;
    n = 0;
    while (ready !== 1'b1 && n < 500) begin
      @(negedge clk);
      n++;
    end
    chk(8'(ready), 8'h01); // host waits for ready
  endtask : wait_ready
  task automatic results();
    if (bad_count == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : results

  // ****************
  // clock, monitor, watchdog
  // ****************
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // each fresh drive of the data bus consumes the oldest expected byte
  always @(negedge clk) begin
    oe_q <= data_oe;
    if (data_oe === 1'b1 && oe_q !== 1'b1) begin
      if (exp_q.size() > 0) chk(data_out, exp_q.pop_front()); // read data
      else chk(data_out, 8'hxx); // drive was not expected
    end
  end
  // whole run is about 2100 cycles
  initial begin
    repeat (30000) @(negedge clk);
    bad_count++;
    results();
  end

  // ****************
  // main sequence
  // ****************
  initial begin
    logic       lv;
    logic [5:0] idx;
    int         cnt;
    rst = 1'b1; hrst = 1'b0; ide = 1'b0; core_irq = 1'b0; irq_dis = 1'b0;
    core_cmd = 1'b0; tf_req = '0; bad_count = 0; check_count = 0;
    void'($urandom(32'h81c23640));
    repeat (10) @(negedge clk);
    rst = 1'b0;
    chk(8'(init), 8'h01); // init after power-on
    rd(10'h200, 8'h00); // option reset
    rd(10'h202, 8'h00); // status reset
    rd(10'h204, 8'h0c); // pin reset
    rd(10'h206, 8'h00); // socket reset
    wait_ready();
    wr(10'h206, 8'hff); // only copy bit kept
    rd(10'h206, 8'h10); // copy readable
    for (int i = 0; i < 5; i++) begin
      cmd(); // keep card awake
      lv  = 1'($urandom_range(1, 0));
      idx = (i < 4) ? 6'(i) : 6'($urandom_range(63, 4));
      wr(10'h200, {1'b0, lv, idx}); // after socket
      rd(10'h200, {1'b0, lv, idx}); // select readback
      chk(8'(map), 8'(i < 4 ? i : 4)); // mode decode
      if (i < 4) tf(hit_tab[i], 1'b1); // inside window
      if (i != 1) tf(miss_tab[i], 1'b0); // outside window
    end
    cmd(); // keep card awake
    wr(10'h200, 8'h02); // primary io mode
    wr(10'h202, 8'h44); // request sleep
    chk(8'(ready), 8'h00); // busy on change
    chk(8'(sleep), 8'h01); // sleeping
    chk(8'(sts_n), 8'h00); // pin low
    rd(10'h202, 8'hc4); // change flag set
    wait_ready();
    rd(10'h204, 8'h2e); // changed and live ready
    wr(10'h202, 8'h04); // disable status change
    chk(8'(sts_n), 8'h01); // pin held high
    wr(10'h202, 8'h00); // back to active
    chk(8'(ready), 8'h00); // busy on change
    chk(8'(sleep), 8'h00); // awake
    wait_ready();
    wr(10'h204, 8'h00); // host clears flag
    rd(10'h204, 8'h0e); // flag cleared
    rd(10'h202, 8'h00); // change flag follows
    cmd(); // keep card awake
    wr(10'h200, 8'h42); // level mode
    core_irq = 1'b1;
    repeat (3) @(negedge clk);
    chk(8'(irq_n), 8'h00); // level request
    rd(10'h202, 8'h02); // pending shown
    irq_dis = 1'b1;
    rd(10'h202, 8'h00); // disabled reads zero
    irq_dis = 1'b0;
    core_irq = 1'b0;
    wr(10'h200, 8'h02); // pulse mode
    cnt = 0;
    core_irq = 1'b1;
    repeat (10) begin
      @(negedge clk);
      cnt += (irq_n === 1'b0);
    end
    chk(8'(cnt), 8'h01); // single pulse
    core_irq = 1'b0;
    wr(10'h202, 8'hbb); // read-only bits ignored
    chk(8'(narrow), 8'h01); // narrow host
    rd(10'h202, 8'h20); // only narrow stored
    rd(10'h208, 8'h00); // other offset
    host.cyc(1'b0, 10'h207, 8'h00); // odd address not driven
    cmd(); // keep card awake
    wr(10'h200, 8'hc3); // soft reset
    chk(8'(init), 8'h01); // card in reset
    chk(8'(map), 8'(CCR_MAP_MEM)); // memory mode
    chk(8'(narrow), 8'h00); // config cleared
    rd(10'h200, 8'h80); // bit stays set
    rd(10'h206, 8'h00); // socket cleared
    wr(10'h200, 8'h00); // release soft reset
    wait_ready();
    rd(10'h200, 8'h00); // index zero
    wr(10'h206, 8'h10); // copy set before hard reset
    hrst = 1'b1;
    repeat (6) @(negedge clk);
    hrst = 1'b0;
    chk(8'(init), 8'h01); // init restarted
    rd(10'h206, 8'h00); // config cleared
    wait_ready();
    ide = 1'b1;
    repeat (6) @(negedge clk);
    host.cyc(1'b1, 10'h206, 8'h10); // write refused
    host.cyc(1'b0, 10'h206, 8'h00); // read not driven
    ide = 1'b0;
    repeat (6) @(negedge clk);
    rd(10'h206, 8'h00); // register unchanged
    cmd(); // restart idle timer
    repeat (1100) @(negedge clk);
    chk(8'(sleep), 8'h01); // idle sleep
    cmd(); // command wakes
    cnt = 0;
    while (sleep !== 1'b0 && cnt < 100) begin
      @(negedge clk);
      cnt++;
    end
    chk(8'(sleep), 8'h00); // wake on command
    repeat (5) @(negedge clk);
    results();
  end
endmodule : tb
